// *** src/cdr_pkg.sv ***
// Package: register map, field layouts, reset values and timing for the wake clock recovery
package cdr_pkg;
    // Register word offsets (byte addresses, one aligned 32-bit word each)
    localparam logic [7:0] CTRL_ONE_OFFS = 8'h00;
    localparam logic [7:0] CTRL_TWO_OFFS = 8'h04;
    localparam logic [7:0] QUANTA_OFFS = 8'h08;
    localparam logic [7:0] SAMPLE_OFFS = 8'h0c;
    localparam logic [7:0] UPPER_OFFS = 8'h10;
    localparam logic [7:0] LOWER_OFFS = 8'h14;
    localparam logic [7:0] MODE_OFFS = 8'h18;
    localparam logic [7:0] STATUS_OFFS = 8'h1c;
    localparam logic [7:0] BITTIME_OFFS = 8'h20;
    // Field positions
    localparam int EN_BIT = 0;
    localparam int FD_EN_BIT = 1;
    localparam int ERRDIS_BIT = 2;
    localparam int FILT_LSB = 4;
    localparam int WAKE_CLR_BIT = 8;
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_WAKE_BIT = 1;
    localparam int ST_RESTART_BIT = 2;
    localparam int ST_ERRDIS_BIT = 3;
    localparam int ST_SOFOK_BIT = 4;
    // Widths and reset values
    localparam int BT_W = 8;
    localparam logic [1:0] CLKSEL_RST = 2'h0;
    localparam logic [BT_W-1:0] QUANTA_RST = 8'h14;
    localparam logic [5:0] SAMPLE_RST = 6'h33;
    localparam logic [BT_W-1:0] UPPER_RST = 8'h16;
    localparam logic [BT_W-1:0] LOWER_RST = 8'h12;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_STOP = 3'h2;
    localparam logic [2:0] MODE_SLEEP = 3'h3;
    localparam logic [1:0] FILT_GLITCH4 = 2'h1;
    localparam logic [1:0] FILT_GLITCH10 = 2'h2;
    // Timing
    localparam int CLK_HZ = 20000000;
    localparam real SILENCE_S = 0.6;
    localparam real SILENCE_MAX_S = 1.2;
    localparam int SILENCE_CYC = int'(SILENCE_S * CLK_HZ);
    localparam real WAKE_US = 100.0;
    localparam int WAKE_CYC = int'(WAKE_US * CLK_HZ / 1.0e6);
    localparam real BIT_MIN_US = 1.0;
    localparam int BIT_MIN_Q = int'(BIT_MIN_US * CLK_HZ / 1.0e6);
    localparam int IDLE_BITS_MIN = 6;
    localparam int IDLE_BITS_MAX = 10;
    localparam int IDLE_BITS = 7;
    localparam real GLITCH4_PCT = 5.0;
    localparam real GLITCH10_PCT = 2.5;
    localparam real DOM4_PCT = 17.5;
    localparam real DOM10_PCT = 8.75;
    localparam int ACQ_EDGES = 4;
endpackage

// *** src/bit_time_if.sv ***
// Interface: bit time handoff between the register block and the bit timer
`timescale 1ns/1ps
interface bit_time_if;
    import cdr_pkg::*;
    logic [BT_W-1:0] quanta;
    logic [BT_W-1:0] upper;
    logic [BT_W-1:0] lower;
    logic enable;
    logic [BT_W-1:0] bitTime;
    logic restart;
    modport ctrl (output quanta, output upper, output lower, output enable,
        input bitTime, input restart);
    modport timer (input quanta, input upper, input lower, input enable,
        output bitTime, output restart);
endinterface

// *** src/cdr_bit_timer.sv ***
// Recovery bit timer: measures edge spacing and tracks the bit time within limits
`timescale 1ns/1ps
module cdr_bit_timer
    import cdr_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rstSyncN, // Synchronised reset, active low
    input wire logic rxEdge, // One-cycle pulse on each bus edge
    bit_time_if.timer bt // Settings in, bit time out
);
    //----------------------------------------------------------------
    // Edge spacing measurement
    //----------------------------------------------------------------
    logic [BT_W+3:0] spanReg;
    logic [BT_W+5:0] accReg;
    logic [2:0] nEdgeReg;
    logic [BT_W-1:0] bitTimeReg;
    logic restartReg;
    logic [BT_W-1:0] estimate;
    logic [BT_W-1:0] nextBt;
    logic atLimit;
    logic [BT_W+3:0] rounded;
    logic [BT_W+3:0] nBits;
    logic [BT_W+5:0] accNext;

    // Round spacing to whole bits so multi-bit gaps still count
    assign nBits = (bitTimeReg == '0) ? '0 :
        (spanReg + {5'h0, bitTimeReg[BT_W-1:1]}) / {4'h0, bitTimeReg};
    assign rounded = (nBits == '0) ? {4'h0, bitTimeReg} : spanReg / nBits;
    assign accNext = accReg + {2'h0, rounded};
    // Mean of the four spans: drop the two low bits of the sum
    assign estimate = accNext[2 +: BT_W];
    // Estimate at or beyond either limit is not used; a hit reloads the quanta and flags restart
    assign atLimit = (estimate >= bt.upper) || (estimate <= bt.lower);
    assign nextBt = atLimit ? bt.quanta : estimate;

    // Span counter restarts on every edge
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            spanReg <= '0;
        else if (rxEdge)
            spanReg <= '0;
        else if (spanReg != '1)
            spanReg <= spanReg + 1'b1;
    end

    // Accumulate and update; disabled tracking pins bit time to the quanta
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            accReg <= '0;
            nEdgeReg <= '0;
            bitTimeReg <= QUANTA_RST;
            restartReg <= 1'b0;
        end
        else if (!bt.enable)
        begin
            accReg <= '0;
            nEdgeReg <= '0;
            bitTimeReg <= bt.quanta;
            restartReg <= 1'b0;
        end
        else if (rxEdge && nEdgeReg == 3'(ACQ_EDGES - 1))
        begin
            accReg <= '0;
            nEdgeReg <= '0;
            bitTimeReg <= nextBt;
            restartReg <= atLimit;
        end
        else if (rxEdge)
        begin
            accReg <= accNext;
            nEdgeReg <= nEdgeReg + 1'b1;
            restartReg <= 1'b0;
        end
        else
            restartReg <= 1'b0;
    end

    assign bt.bitTime = bitTimeReg;
    assign bt.restart = restartReg;
endmodule // cdr_bit_timer

// *** src/can_wake_clock_recovery.sv ***
// Top: wake receiver clock recovery, bus silence, wake signalling and tolerant filters
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module can_wake_clock_recovery
    import cdr_pkg::*;
#(
    parameter int SILENCE_CYCLES = SILENCE_CYC // Silence timeout, shorten in simulation
)
(
    input wire logic clk, // 20 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [7:0] address, // Avalon byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte enables
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait
    input wire logic rxPin, // Bus receive pin, low is dominant
    input wire logic wakeValid, // Pulse: valid wake pattern or frame ended
    output logic wakeIrq, // Wake interrupt in stop mode
    output logic supplyOn, // Main supply output enable
    output logic frameStart, // Pulse: accepted start of frame
    output logic domBit // Pulse: recognised flexible-phase dominant bit
);
    //----------------------------------------------------------------
    // Reset release and pin synchronisers
    //----------------------------------------------------------------
    logic [1:0] rstPipe;
    logic rstSyncN;
    logic rxMeta;
    logic rxSync;
    logic rxLast;
    logic rxEdge;

    // Reset released through two flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rstPipe <= 2'h0;
        else
            rstPipe <= {rstPipe[0], 1'b1};
    end
    assign rstSyncN = rstPipe[1];

    // Two-flop pin sync; only the second stage feeds logic
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            rxMeta <= 1'b1;
            rxSync <= 1'b1;
            rxLast <= 1'b1;
        end
        else
        begin
            rxMeta <= rxPin;
            rxSync <= rxMeta;
            rxLast <= rxSync;
        end
    end
    assign rxEdge = rxSync ^ rxLast;

    //----------------------------------------------------------------
    // Register file
    //----------------------------------------------------------------
    logic enReg;
    logic fdEnReg;
    logic errDisReg;
    logic [1:0] filtReg;
    logic [1:0] clkSelReg;
    logic [BT_W-1:0] quantaReg;
    logic [5:0] sampleReg;
    logic [BT_W-1:0] upperReg;
    logic [BT_W-1:0] lowerReg;
    logic [2:0] modeReg;
    logic wakeReg;
    logic restartSeenReg;
    logic activeReg;
    logic sofOkReg;
    logic ackReg;
    logic access;
    logic wrCtrl1;
    logic wakeClr;
    logic silenceHit;
    logic wakeSet;
    logic [31:0] rdMux;
    bit_time_if bt ();

    // One wait state: the answer comes on the second edge of a request
    assign access = (read || write) && !ackReg;
    assign wrCtrl1 = access && write && address == CTRL_ONE_OFFS && byteenable[0];
    assign wakeClr = access && write && address == CTRL_ONE_OFFS && byteenable[1]
        && writedata[WAKE_CLR_BIT];

    // Ack flop makes waitrequest low for exactly one cycle per request
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            ackReg <= 1'b0;
        else
            ackReg <= access;
    end

    // Configuration writes; the enable, quanta and limits written here steer the timer
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            enReg <= 1'b0;
            fdEnReg <= 1'b0;
            filtReg <= 2'h0;
            clkSelReg <= CLKSEL_RST;
            quantaReg <= QUANTA_RST;
            sampleReg <= SAMPLE_RST;
            upperReg <= UPPER_RST;
            lowerReg <= LOWER_RST;
            modeReg <= MODE_OFF;
        end
        else if (access && write && byteenable[0])
        begin
            unique case (address)
                CTRL_ONE_OFFS:
                begin
                    enReg <= writedata[EN_BIT];
                    fdEnReg <= writedata[FD_EN_BIT];
                    filtReg <= writedata[FILT_LSB +: 2];
                end
                CTRL_TWO_OFFS: clkSelReg <= writedata[1:0];
                QUANTA_OFFS: quantaReg <= writedata[BT_W-1:0];
                SAMPLE_OFFS: sampleReg <= writedata[5:0];
                UPPER_OFFS: upperReg <= writedata[BT_W-1:0];
                LOWER_OFFS: lowerReg <= writedata[BT_W-1:0];
                MODE_OFFS: modeReg <= writedata[2:0];
                default: ;
            endcase
        end
    end

    // Error counter disable: timeout clear wins over a write
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            errDisReg <= 1'b0;
        else if (silenceHit)
            errDisReg <= 1'b0;
        else if (wrCtrl1)
            errDisReg <= writedata[ERRDIS_BIT];
    end

    // Read mux over mapped words; unmapped reads return zero
    always_comb
    begin
        rdMux = 32'h0;
        unique case (address)
            CTRL_ONE_OFFS: rdMux = {26'h0, filtReg, 1'b0, errDisReg, fdEnReg, enReg};
            CTRL_TWO_OFFS: rdMux = {30'h0, clkSelReg};
            QUANTA_OFFS: rdMux = {24'h0, quantaReg};
            SAMPLE_OFFS: rdMux = {26'h0, sampleReg};
            UPPER_OFFS: rdMux = {24'h0, upperReg};
            LOWER_OFFS: rdMux = {24'h0, lowerReg};
            MODE_OFFS: rdMux = {29'h0, modeReg};
            STATUS_OFFS: rdMux = {27'h0, sofOkReg, errDisReg, restartSeenReg, wakeReg,
                activeReg};
            BITTIME_OFFS: rdMux = {24'h0, bt.bitTime};
            default: rdMux = 32'h0;
        endcase
    end

    // Read data and wait registered
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            readdata <= 32'h0;
            waitrequest <= 1'b1;
        end
        else
        begin
            readdata <= rdMux;
            waitrequest <= !access;
        end
    end

    //----------------------------------------------------------------
    // Bit timer
    //----------------------------------------------------------------
    assign bt.quanta = quantaReg;
    assign bt.upper = upperReg;
    assign bt.lower = lowerReg;
    assign bt.enable = enReg;

    cdr_bit_timer timer (
        .clk(clk),
        .rstSyncN(rstSyncN),
        .rxEdge(rxEdge),
        .bt(bt.timer)
    );

    // Restart seen flag is sticky until the enable is rewritten
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            restartSeenReg <= 1'b0;
        else if (bt.restart)
            restartSeenReg <= 1'b1;
        else if (wrCtrl1)
            restartSeenReg <= 1'b0;
    end

    //----------------------------------------------------------------
    // Bus silence timeout
    //----------------------------------------------------------------
    logic [24:0] silenceReg;
    // Only an active bus can time out, so the hit is a single pulse
    assign silenceHit = activeReg && (silenceReg == 25'(SILENCE_CYCLES - 1));

    // Any edge restarts the count; 0.6 s lies inside the allowed window
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            silenceReg <= '0;
            activeReg <= 1'b0;
        end
        else if (rxEdge)
        begin
            silenceReg <= '0;
            activeReg <= 1'b1;
        end
        else if (silenceHit)
            activeReg <= 1'b0;
        else if (activeReg)
            silenceReg <= silenceReg + 1'b1;
    end

    //----------------------------------------------------------------
    // Wake signalling
    //----------------------------------------------------------------
    // Wake is flagged the cycle after it arrives, far under 100 us
    assign wakeSet = wakeValid;

    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            wakeReg <= 1'b0;
            wakeIrq <= 1'b0;
            supplyOn <= 1'b1;
        end
        else
        begin
            wakeReg <= wakeSet || (wakeReg && !wakeClr);
            if (wakeSet && modeReg == MODE_STOP)
                wakeIrq <= 1'b1;
            else if (wakeClr)
                wakeIrq <= 1'b0;
            if (wakeSet)
                supplyOn <= 1'b1;
            else if (access && write && address == MODE_OFFS && byteenable[0])
                supplyOn <= writedata[2:0] != MODE_SLEEP;
        end
    end

    //----------------------------------------------------------------
    // Tolerant mode filters, measured against the arbitration bit time
    //----------------------------------------------------------------
    logic [BT_W+3:0] domLenReg;
    logic [3:0] idleBitsReg;
    logic [BT_W-1:0] bitPhaseReg;
    logic [BT_W+3:0] glitchLen;
    logic [BT_W+3:0] domMin;
    logic domEnd;
    logic bitTick;

    // Thresholds from the filter grade: glitch 5 or 2.5 %, dominant 17.5 or 8.75 %
    assign glitchLen = (filtReg == FILT_GLITCH10) ? 12'(bt.bitTime / 40) :
        12'(bt.bitTime / 20);
    assign domMin = (filtReg == FILT_GLITCH10) ? 12'((bt.bitTime * 7 + 79) / 80) :
        12'((bt.bitTime * 7 + 39) / 40);
    assign domEnd = rxEdge && rxSync && domLenReg > glitchLen;
    // Bit timing reaches up to 255 clocks (12.75 us) since the phase counter is 8 bits
    assign bitTick = (bitPhaseReg >= bt.bitTime - 1'b1);

    // Dominant length, recessive bit count, start and dominant pulses
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            domLenReg <= '0;
            idleBitsReg <= '0;
            bitPhaseReg <= '0;
            sofOkReg <= 1'b0;
            frameStart <= 1'b0;
            domBit <= 1'b0;
        end
        else
        begin
            domLenReg <= rxSync ? '0 : domLenReg + 1'b1;
            bitPhaseReg <= (rxEdge || bitTick) ? '0 : bitPhaseReg + 1'b1;
            if (domEnd)
                idleBitsReg <= '0;
            else if (rxSync && bitTick && idleBitsReg != 4'(IDLE_BITS_MAX))
                idleBitsReg <= idleBitsReg + 1'b1;
            sofOkReg <= !fdEnReg || idleBitsReg >= 4'(IDLE_BITS);
            frameStart <= domLenReg == glitchLen && !rxSync && (!fdEnReg
                || idleBitsReg >= 4'(IDLE_BITS));
            domBit <= fdEnReg && domEnd && domLenReg >= domMin;
        end
    end
endmodule // can_wake_clock_recovery

// *** sim/can_wake_clock_recovery_chk.sv ***
// Checker: port assertions for the wake clock recovery block
`timescale 1ns/1ps
module can_wake_clock_recovery_chk
    import cdr_pkg::*;
#(
    parameter int SILENCE_CYCLES = SILENCE_CYC // Silence timeout
)
(
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic [7:0] address, // Address
    input wire logic read, // Read
    input wire logic write, // Write
    input wire logic [31:0] writedata, // Write data
    input wire logic [3:0] byteenable, // Lanes
    input wire logic [31:0] readdata, // Read data
    input wire logic waitrequest, // Wait
    input wire logic rxPin, // Bus line
    input wire logic wakeValid, // Wake end
    input wire logic wakeIrq, // Interrupt
    input wire logic supplyOn, // Supply
    input wire logic frameStart, // Frame start
    input wire logic domBit // Dominant bit
);
    logic [2:0] modeSeen;
    logic [7:0] upSeen;
    logic [7:0] lowSeen;
    logic [2:0] rstSeen;
    wire logic wrDone = write && !waitrequest && byteenable[0];
    wire logic rdDone = read && !waitrequest;
    // Block leaves reset two edges after the pin; one more edge of margin here
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rstSeen <= 3'h0;
        else
            rstSeen <= {rstSeen[1:0], 1'b1};
    end
    // Shadow of mode and limits, so answers are judged against what was written
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            modeSeen <= MODE_OFF;
            upSeen <= UPPER_RST;
            lowSeen <= LOWER_RST;
        end
        else if (wrDone)
        begin
            modeSeen <= (address == MODE_OFFS) ? writedata[2:0] : modeSeen;
            upSeen <= (address == UPPER_OFFS) ? writedata[7:0] : upSeen;
            lowSeen <= (address == LOWER_OFFS) ? writedata[7:0] : lowSeen;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstSeen[2]);
    sequence sleepWr;
        wrDone && address == MODE_OFFS && writedata[2:0] == MODE_SLEEP;
    endsequence
    sequence wakeInStop;
        wakeValid && modeSeen == MODE_STOP;
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ack_next: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    a_ack_single: assert property (!waitrequest |=> waitrequest)
        else $error("bus answer held too long");
    a_unmapped_zero: assert property (
        rdDone && address > BITTIME_OFFS |-> readdata == 32'h0) else $error("unmapped read");
    a_bit_limits: assert property (
        rdDone && address == BITTIME_OFFS |-> readdata[7:0] >= lowSeen && readdata[7:0] <= upSeen)
        else $error("bit time outside limits");
    a_stop_irq: assert property (wakeInStop |=> wakeIrq) else $error("no wake interrupt");
    a_irq_cause: assert property ($rose(wakeIrq) |-> $past(wakeValid))
        else $error("interrupt without wake");
    a_sleep_off: assert property (sleepWr |-> ##[0:2] !supplyOn) else $error("supply on");
    a_wake_supply: assert property (wakeValid |-> ##[1:2] supplyOn) else $error("no supply");
    a_sof_pulse: assert property (frameStart |=> !frameStart) else $error("start held");
    a_dom_pulse: assert property (domBit |=> !domBit) else $error("dominant held");
endmodule // can_wake_clock_recovery_chk

bind can_wake_clock_recovery can_wake_clock_recovery_chk #(.SILENCE_CYCLES(SILENCE_CYCLES))
    chk_inst (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .rxPin(rxPin), .wakeValid(wakeValid), .wakeIrq(wakeIrq),
    .supplyOn(supplyOn), .frameStart(frameStart), .domBit(domBit));

// *** sim/can_node_model.sv ***
// Partner model: a bus node driving the receive line and the wake end pulse
`timescale 1ns/1ps
module can_node_model
(
    input wire logic clk, // System clock
    output logic rxPin, // Receive line, low is dominant
    output logic wakeValid // One-cycle wake end pulse
);
    // Line rests recessive, the level the bus bias pulls it to
    initial
    begin
        rxPin = 1'b1;
        wakeValid = 1'b0;
    end
    // One level for a number of clocks, changed just after an edge
    task automatic drive(input logic lvl, input int cyc);
        @(posedge clk);
        rxPin <= lvl;
        repeat (cyc - 1) @(posedge clk);
    endtask
    // Alternating bits of cyc clocks each, then one recessive bit
    task automatic toggle(input int n, input int cyc);
        for (int i = 0; i < n; i++)
            drive(~rxPin, cyc);
        drive(1'b1, cyc);
    endtask
    // Decoder reports a finished wake pattern or frame
    task automatic wake;
        @(posedge clk);
        wakeValid <= 1'b1;
        @(posedge clk);
        wakeValid <= 1'b0;
    endtask
endmodule // can_node_model

// *** sim/tb.sv ***
// Testbench: registers, recovery, silence, wake and tolerant filters against a bench model
`timescale 1ns/1ps
module tb;
    import cdr_pkg::*;
    localparam int SIL = 200;
    logic clk, rst_n, read, write, waitrequest, rxPin, wakeValid;
    logic wakeIrq, supplyOn, frameStart, domBit;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata, q;
    int err_total, checks, sofCount, domCount;
    int regm[7];
    int mask[7] = '{32'h37, 32'h3, 32'hff, 32'h3f, 32'hff, 32'hff, 32'h7};
    can_wake_clock_recovery #(.SILENCE_CYCLES(SIL)) can_wake_clock_recovery_inst (.clk(clk),
        .rst_n(rst_n), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .rxPin(rxPin), .wakeValid(wakeValid), .wakeIrq(wakeIrq), .supplyOn(supplyOn),
        .frameStart(frameStart), .domBit(domBit));
    can_node_model can_node_model_inst (.clk(clk), .rxPin(rxPin), .wakeValid(wakeValid));
    // 50 ns clock
    initial clk = 1'b0;
    always #25 clk = ~clk;
    // Pulses counted mid-cycle, where they have settled
    always @(negedge clk)
    begin
        sofCount += (frameStart === 1'b1);
        domCount += (domBit === 1'b1);
    end
    task automatic finish_test;
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: level %b, expected %b", $time, got, exp);
        end
    endtask
    // One bus cycle; held until a rising edge sees waitrequest low, data taken there
    task automatic bus(input logic isWr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= isWr;
        read <= !isWr;
        for (n = 0; n < 64; n++)
        begin
            @(posedge clk);
            if (waitrequest === 1'b0)
                break;
        end
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        cmp_bit(n < 64, 1'b1);
        if (n >= 64)
            finish_test();
    endtask
    // Write through lane 0 and mirror it into the bench model
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'h1);
        if (a <= MODE_OFFS && a[1:0] == 2'b00)
            regm[a[7:2]] = d & mask[a[7:2]];
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        cmp_word(q, exp);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst_n, read, write, address, writedata, byteenable} = '0;
        {err_total, checks, sofCount, domCount} = '0;
        regm = '{0, CLKSEL_RST, QUANTA_RST, SAMPLE_RST, UPPER_RST, LOWER_RST, MODE_OFF};
        void'($urandom(28));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 1; i < 6; i++)
            chk(8'(i * 4), 32'(regm[i]));
        chk(BITTIME_OFFS, 32'(QUANTA_RST));
        for (int i = 0; i < 3; i++)
        begin
            wr(CTRL_TWO_OFFS, $urandom);
            wr(SAMPLE_OFFS, $urandom);
            chk(CTRL_TWO_OFFS, 32'(regm[1]));
            chk(SAMPLE_OFFS, 32'(regm[3]));
        end
        // Refused: unmapped place, and a write without lane 0
        wr(8'h24, $urandom);
        chk(8'h24, 32'h0);
        bus(1'b1, QUANTA_OFFS, 32'h55, 4'he);
        chk(QUANTA_OFFS, 32'(regm[2]));
        // Setup in order with recovery off; timing stays on plain quanta
        wr(MODE_OFFS, 32'(MODE_OFF));
        wr(CTRL_ONE_OFFS, 32'h0);
        wr(CTRL_TWO_OFFS, 32'h1);
        wr(QUANTA_OFFS, 32'h13);
        wr(UPPER_OFFS, 32'h16);
        wr(LOWER_OFFS, 32'h12);
        can_node_model_inst.toggle(12, 21);
        chk(BITTIME_OFFS, 32'h13);
        wr(CTRL_ONE_OFFS, 32'((1 << EN_BIT) | (1 << ERRDIS_BIT)));
        can_node_model_inst.toggle(12, 21);
        bus(1'b0, BITTIME_OFFS, 32'h0, 4'hf);
        cmp_bit(q[7:0] !== 8'h13, 1'b1);
        // Silence: still active short of the timeout, inactive past it
        repeat (SIL - 60) @(posedge clk);
        bus(1'b0, STATUS_OFFS, 32'h0, 4'hf);
        cmp_bit(q[ST_ACTIVE_BIT], 1'b1);
        repeat (60) @(posedge clk);
        bus(1'b0, STATUS_OFFS, 32'h0, 4'hf);
        cmp_bit(q[ST_ACTIVE_BIT], 1'b0);
        regm[0] = regm[0] & ~(1 << ERRDIS_BIT);
        chk(CTRL_ONE_OFFS, 32'(regm[0]));
        // Edges too far apart push the estimate onto the upper limit
        can_node_model_inst.toggle(12, 30);
        bus(1'b0, STATUS_OFFS, 32'h0, 4'hf);
        cmp_bit(q[ST_RESTART_BIT], 1'b1);
        chk(BITTIME_OFFS, 32'h13);
        // Wake in stop mode, clear on lane 1, then wake out of sleep
        wr(MODE_OFFS, 32'(MODE_STOP));
        can_node_model_inst.wake();
        @(negedge clk);
        cmp_bit(wakeIrq, 1'b1);
        bus(1'b0, STATUS_OFFS, 32'h0, 4'hf);
        cmp_bit(q[ST_WAKE_BIT], 1'b1);
        bus(1'b1, CTRL_ONE_OFFS, 32'h100, 4'h2);
        @(negedge clk);
        cmp_bit(wakeIrq, 1'b0);
        wr(MODE_OFFS, 32'(MODE_SLEEP));
        @(negedge clk);
        cmp_bit(supplyOn, 1'b0);
        can_node_model_inst.wake();
        @(negedge clk);
        cmp_bit(supplyOn, 1'b1);
        cmp_bit(wakeIrq, 1'b0);
        // Tolerant mode, 40-clock arbitration bits, recovery off
        wr(MODE_OFFS, 32'(MODE_OFF));
        wr(CTRL_ONE_OFFS, 32'h0);
        wr(QUANTA_OFFS, 32'h28);
        wr(UPPER_OFFS, 32'h2c);
        wr(LOWER_OFFS, 32'h24);
        wr(CTRL_ONE_OFFS, 32'((1 << FD_EN_BIT) | (FILT_GLITCH4 << FILT_LSB)));
        chk(CTRL_ONE_OFFS, 32'(regm[0]));
        sofCount = 0;
        domCount = 0;
        can_node_model_inst.drive(1'b1, 440);
        can_node_model_inst.drive(1'b0, 1);
        can_node_model_inst.drive(1'b1, 40);
        cmp_word(32'(sofCount), 32'h0);
        can_node_model_inst.drive(1'b0, 40);
        can_node_model_inst.toggle(8, 10);
        cmp_word(32'(sofCount), 32'h1);
        cmp_word(32'(domCount), 32'h5);
        can_node_model_inst.drive(1'b1, 200);
        can_node_model_inst.drive(1'b0, 40);
        can_node_model_inst.drive(1'b1, 440);
        can_node_model_inst.drive(1'b0, 40);
        can_node_model_inst.drive(1'b1, 80);
        cmp_word(32'(sofCount), 32'h2);
        finish_test();
    end
endmodule // tb
